// ==== spwm_defines.svh ====
// Register offsets, field positions, reset values and timing counts of the PWM controller
`ifndef SPWM_DEFINES_SVH
`define SPWM_DEFINES_SVH
// ==========================================================================
// Register pointers
`define SPWM_REG_PRIMARY     8'h00
`define SPWM_REG_SECONDARY   8'h01
`define SPWM_REG_CHAN_FIRST  8'h06
`define SPWM_REG_CHAN_LAST   8'h45
`define SPWM_REG_BCAST_FIRST 8'hFA
`define SPWM_REG_BCAST_OFFH  8'hFD
`define SPWM_REG_PRESCALE    8'hFE
`define SPWM_REG_TEST        8'hFF
// ==========================================================================
// Primary mode bits
`define SPWM_P_RESUME   7
`define SPWM_P_EXTERNAL_CLOCK_SELECT   6
`define SPWM_P_AUTOINC  5
`define SPWM_P_SLEEP    4
`define SPWM_P_SECONDARY_ADDR1_ENABLE     3
`define SPWM_P_SECONDARY_ADDR2_ENABLE     2
`define SPWM_P_SECONDARY_ADDR3_ENABLE     1
`define SPWM_P_BCAST    0
// Secondary mode bits
`define SPWM_S_INVERT   4
`define SPWM_S_TIMING   3
`define SPWM_S_DRIVE    2
// Channel high-byte force bit
`define SPWM_FULL_BIT   4
// ==========================================================================
// Reset values
`define SPWM_PRIMARY_RST   8'h11
`define SPWM_SECONDARY_RST 8'h04
`define SPWM_PRESCALE_RST  8'h1E
`define SPWM_ONH_RST       8'h00
`define SPWM_OFFH_RST      8'h10
// ==========================================================================
// Timing
`define SPWM_CLK_HZ        10000000
`define SPWM_OSC_WAKE_US   500
`define SPWM_OSC_WAKE_CYC  ((`SPWM_OSC_WAKE_US * (`SPWM_CLK_HZ / 1000000)))
`endif

// ==== spwm_pkg.sv ====
// Types shared by the PWM controller modules
package spwm_pkg;
  typedef enum logic [1:0] {
    SPWM_BUS_IDLE = 2'b00,
    SPWM_BUS_PTR  = 2'b01,
    SPWM_BUS_DATA = 2'b10
  } spwm_bus_t;
  typedef logic [11:0] spwm_count_t;
endpackage

// ==== spwm_sync.sv ====
// Two flip-flop level synchroniser for pins entering the mclk domain
module spwm_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // Data
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } spwm_sync_t;
  spwm_sync_t state_r;
  spwm_sync_t state_nxt;
  // Refuse widths that the two stages cannot hold
  if (WIDTH < 1) begin : gBadWidth
    $error("width must be positive");
  end
  // Shift the pin through two stages
  always_comb begin
    state_nxt.first  = asyncIn;
    state_nxt.second = state_r.first;
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end
  assign syncOut = state_r.second;
endmodule

// ==== spwm_channel.sv ====
// One PWM channel: compares the shared counter with its on and off points
module spwm_channel
  import spwm_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Counter and controls
  input  wire logic        tick,
  input  wire spwm_pkg::spwm_count_t count,
  input  wire logic        running,
  input  wire logic [12:0] onVal,
  input  wire logic [12:0] offVal,
  // Raw channel level
  output logic             level
);
  typedef struct packed {
    logic lvl;
  } spwm_chan_t;
  spwm_chan_t state_r;
  spwm_chan_t state_nxt;
  // Full off wins over full on, else compare on and off points
  always_comb begin
    state_nxt = state_r;
    if (offVal[12]) begin
      state_nxt.lvl = 1'b0;
    end else if (onVal[12]) begin
      state_nxt.lvl = 1'b1;
    end else if (running && tick) begin
      if (count == offVal[11:0]) begin
        state_nxt.lvl = 1'b0;
      end else if (count == onVal[11:0]) begin
        state_nxt.lvl = 1'b1;
      end
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end
  assign level = state_r.lvl;
  offWins_a: assert property (@(posedge mclk) disable iff (rst)
    offVal[12] |=> !level) else $error("full off not honoured");
endmodule

// ==== spwm_top.sv ====
// Mode control, register file and PWM timing of the 16-channel controller
// ==========================================================================
// How it works
// - Prescaler writes are ignored unless sleep is set.
// - Auto-increment wraps 69 to 0 and 254 to 0.
// - Auto-increment advances the pointer after each data byte read or written.
// - Reading bit 7 gives resume state; writing 1 clears it, 0 does nothing.
// - External clock select is sticky; only reset clears it.
// - Sleep resets to 1; while set, no PWM activity.
// - Sub and broadcast address enables gate address matches.
// - Sleep with channels running sets resume in the first cycle asleep.
// - Writing 1 to resume, awake, restarts channels and clears it.
// - Resume clears on reset, PWM write plus stop, or four-byte load.
// - All channels off before sleep clears resume, contents invalid.
// - Invert bit flips outputs while output enable is low.
// - Outputs update at stop, or at the last byte of a channel.
// - Stop update covers channel registers 06h to 45h, any order.
// - Drive select: 0 open-drain, 1 totem-pole.
// - Disabled-state field sets outputs while output enable is high.
// - A 12-bit counter runs 0..4095; outputs follow on and off matches.
// - Off below on negates in the next counter frame.
// - First byte after address sets the register pointer.
// - Broadcast writes load every channel; reads give zero.
`include "spwm_defines.svh"
module spwm_top
  import spwm_pkg::*;
#(
  parameter int CHANNELS = 16
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Byte port from the serial target front end
  input  wire logic        addrMatch,
  input  wire logic [1:0]  addrKind,
  input  wire logic        byteWrite,
  input  wire logic        byteRead,
  input  wire logic [7:0]  byteIn,
  input  wire logic        busStop,
  input  wire logic        softReset,
  // Clock and output enable pins
  input  wire logic        extClockPin,
  input  wire logic        outEnableN,
  // Register read data and address answer
  output logic [7:0]       byteOut,
  output logic             addrAck,
  // Channel pins and prescaler value
  output logic [CHANNELS-1:0] ledOut,
  output logic [CHANNELS-1:0] ledOutEnN,
  output logic [7:0]       prescaleOut
);
  import spwm_pkg::*;
  // Refuse channel counts that the fixed register map cannot serve
  if (CHANNELS != 16) begin : gBadChannels
    $error("register map serves exactly 16 channels");
  end
  localparam int NREG = CHANNELS * 4;
  // ==========================================================================
  // State
  typedef struct packed {
    logic [7:0]      primary;
    logic [7:0]      secondary;
    logic [7:0]      prescale;
    logic [7:0]      ptr;
    spwm_bus_t       phase;
    logic [NREG*8-1:0] shadow;
    logic [NREG*8-1:0] live;
    logic            pending;
    logic [3:0]      loadMask;
    logic [11:0]     count;
    logic [11:0]     div;
    logic            extPrev;
    logic            wasRunning;
    logic [CHANNELS-1:0] pinOut;
    logic [CHANNELS-1:0] pinEnN;
    logic [7:0]      rdata;
    logic            ack;
  } spwm_state_t;
  spwm_state_t state_r;
  spwm_state_t state_nxt;
  logic extSync;
  logic oeNSync;
  logic [CHANNELS-1:0] level;
  logic tick;
  logic running;
  // Reset image of the channel registers
  function automatic logic [NREG*8-1:0] chanReset();
    logic [NREG*8-1:0] v;
    v = '0;
    for (int c = 0; c < CHANNELS; c++) begin
      v[(c*4+1)*8 +: 8] = `SPWM_ONH_RST;
      v[(c*4+3)*8 +: 8] = `SPWM_OFFH_RST;
    end
    return v;
  endfunction
  localparam logic [NREG*8-1:0] CHAN_RST = chanReset();
  // Pointer step with both wrap points
  function automatic logic [7:0] nextPtr(input logic [7:0] p);
    if (p == `SPWM_REG_CHAN_LAST || p == `SPWM_REG_PRESCALE) begin
      return `SPWM_REG_PRIMARY;
    end
    return p + 8'h01;
  endfunction
  // Mask of writable bits for a channel byte
  function automatic logic [7:0] chanMask(input logic [1:0] sel);
    return sel[0] ? 8'h1F : 8'hFF;
  endfunction
  // ==========================================================================
  // Pin synchronisers
  spwm_sync #(.WIDTH(2)) uSync (
    .mclk    (mclk),
    .rst     (rst),
    .asyncIn ({extClockPin, outEnableN}),
    .syncOut ({extSync, oeNSync})
  );
  // Prescaled tick from the internal clock or the external pin edge
  always_comb begin
    logic srcEdge;
    srcEdge = state_r.primary[`SPWM_P_EXTERNAL_CLOCK_SELECT] ? (extSync && !state_r.extPrev) : 1'b1;
    running = !state_r.primary[`SPWM_P_SLEEP];
    tick = running && srcEdge && (state_r.div == {4'h0, state_r.prescale});
  end
  // ==========================================================================
  // Channels
  for (genvar g = 0; g < CHANNELS; g++) begin : gChan
    spwm_channel uChan (
      .mclk   (mclk),
      .rst    (rst),
      .tick   (tick),
      .count  (state_r.count),
      .running(running),
      .onVal  ({state_r.live[(g*4+1)*8+4], state_r.live[(g*4+1)*8 +: 4],
                state_r.live[(g*4)*8 +: 8]}),
      .offVal ({state_r.live[(g*4+3)*8+4], state_r.live[(g*4+3)*8 +: 4],
                state_r.live[(g*4+2)*8 +: 8]}),
      .level  (level[g])
    );
  end
  // ==========================================================================
  // Next state
  always_comb begin
    logic [7:0] p;
    logic [7:0] idx;
    logic allOff;
    logic chanWr;
    logic pendSet;
    state_nxt = state_r;
    p = state_r.ptr;
    idx = p - `SPWM_REG_CHAN_FIRST;
    chanWr = 1'b0;
    pendSet = 1'b0;
    allOff = 1'b1;
    state_nxt.extPrev = extSync;
    // Counter and divider
    if (running && (state_r.primary[`SPWM_P_EXTERNAL_CLOCK_SELECT] ? (extSync && !state_r.extPrev) : 1'b1)) begin
      state_nxt.div = tick ? 12'h000 : state_r.div + 12'h001;
    end
    if (tick) begin
      state_nxt.count = state_r.count + 12'h001;
    end
    for (int c = 0; c < CHANNELS; c++) begin
      if (!state_r.live[(c*4+3)*8+4]) allOff = 1'b0;
    end
    pendSet = state_r.wasRunning && !running && !allOff;
    // Resume flag set in the first cycle asleep with channels left running
    if (state_r.wasRunning && !running && !allOff) begin
      state_nxt.count = 12'h000;
      state_nxt.wasRunning = 1'b0;
      state_nxt.pending = 1'b1;
    end else if (state_r.wasRunning && !running) begin
      state_nxt.wasRunning = 1'b0;
      state_nxt.pending = 1'b0;
    end else if (running) begin
      state_nxt.wasRunning = 1'b1;
    end
    // Address answer
    state_nxt.ack = addrMatch && (addrKind == 2'd0 ? 1'b1 :
                    addrKind == 2'd1 ? state_r.primary[`SPWM_P_BCAST] :
                    addrKind == 2'd2 ? state_r.primary[`SPWM_P_SECONDARY_ADDR1_ENABLE] :
                    state_r.primary[`SPWM_P_SECONDARY_ADDR2_ENABLE] | state_r.primary[`SPWM_P_SECONDARY_ADDR3_ENABLE]);
    if (addrMatch) state_nxt.phase = SPWM_BUS_PTR;
    // Byte writes
    if (byteWrite && state_r.phase == SPWM_BUS_PTR) begin
      state_nxt.ptr = byteIn;
      state_nxt.phase = SPWM_BUS_DATA;
    end else if (byteWrite && state_r.phase == SPWM_BUS_DATA) begin
      if (p == `SPWM_REG_PRIMARY) begin
        state_nxt.primary[5:0] = byteIn[5:0];
        if (byteIn[`SPWM_P_EXTERNAL_CLOCK_SELECT]) state_nxt.primary[`SPWM_P_EXTERNAL_CLOCK_SELECT] = 1'b1;
        if (byteIn[`SPWM_P_RESUME] && state_r.pending && running) begin
          state_nxt.live = state_r.shadow;
          state_nxt.pending = 1'b0;
        end else if (byteIn[`SPWM_P_RESUME]) begin
          state_nxt.pending = 1'b0;
        end
      end else if (p == `SPWM_REG_SECONDARY) begin
        state_nxt.secondary = {3'b000, byteIn[4:0]};
      end else if (p >= `SPWM_REG_CHAN_FIRST && p <= `SPWM_REG_CHAN_LAST) begin
        state_nxt.shadow[idx*8 +: 8] = byteIn & chanMask(idx[1:0]);
        chanWr = 1'b1;
        state_nxt.loadMask = state_r.loadMask | (4'h1 << idx[1:0]);
        if (state_r.secondary[`SPWM_S_TIMING] && idx[1:0] == 2'd3 &&
            (state_r.loadMask | 4'h8) == 4'hF) begin
          state_nxt.live[(idx-8'd3)*8 +: 32] = state_nxt.shadow[(idx-8'd3)*8 +: 32];
          state_nxt.loadMask = 4'h0;
          state_nxt.pending = 1'b0;
        end
      end else if (p >= `SPWM_REG_BCAST_FIRST && p <= `SPWM_REG_BCAST_OFFH) begin
        for (int c = 0; c < CHANNELS; c++) begin
          state_nxt.shadow[(c*4+p-`SPWM_REG_BCAST_FIRST)*8 +: 8] =
            byteIn & chanMask(p[1:0] - 2'd2);
        end
        chanWr = 1'b1;
      end else if (p == `SPWM_REG_PRESCALE && state_r.primary[`SPWM_P_SLEEP]) begin
        state_nxt.prescale = byteIn;
      end
      if (state_r.primary[`SPWM_P_AUTOINC]) state_nxt.ptr = nextPtr(p);
    end
    // Byte reads
    if (byteRead) begin
      case (1'b1)
        p == `SPWM_REG_PRIMARY:
          state_nxt.rdata = {state_r.pending, state_r.primary[6:0]};
        p == `SPWM_REG_SECONDARY: state_nxt.rdata = state_r.secondary;
        p >= `SPWM_REG_CHAN_FIRST && p <= `SPWM_REG_CHAN_LAST:
          state_nxt.rdata = state_r.shadow[idx*8 +: 8];
        p == `SPWM_REG_PRESCALE: state_nxt.rdata = state_r.prescale;
        default: state_nxt.rdata = 8'h00;
      endcase
      if (state_r.primary[`SPWM_P_AUTOINC]) state_nxt.ptr = nextPtr(p);
    end
    // Stop applies staged channel bytes while the timing bit is clear
    if (busStop) begin
      state_nxt.phase = SPWM_BUS_IDLE;
      state_nxt.loadMask = 4'h0;
      if (!state_r.secondary[`SPWM_S_TIMING] && state_r.live != state_r.shadow) begin
        state_nxt.live = state_r.shadow;
        state_nxt.pending = 1'b0;
      end
    end
    if (!state_r.secondary[`SPWM_S_TIMING] && chanWr) begin
      state_nxt.live = state_r.live;
    end
    // Output pins: enabled, disabled field, polarity, drive
    for (int c = 0; c < CHANNELS; c++) begin
      if (!oeNSync) begin
        state_nxt.pinOut[c] = level[c] ^ state_r.secondary[`SPWM_S_INVERT];
        state_nxt.pinEnN[c] = !state_r.secondary[`SPWM_S_DRIVE] &&
                              state_nxt.pinOut[c];
      end else begin
        state_nxt.pinOut[c] = state_r.secondary[0];
        state_nxt.pinEnN[c] = state_r.secondary[1] ||
          (state_r.secondary[0] && !state_r.secondary[`SPWM_S_DRIVE]);
      end
      if (state_nxt.pinEnN[c]) state_nxt.pinOut[c] = 1'b0;
    end
    // Entering sleep with live channels outranks a clear in the same cycle
    if (pendSet) state_nxt.pending = 1'b1;
    // Software reset returns every register to its default
    if (softReset) begin
      state_nxt.primary = `SPWM_PRIMARY_RST;
      state_nxt.secondary = `SPWM_SECONDARY_RST;
      state_nxt.prescale = `SPWM_PRESCALE_RST;
      state_nxt.shadow = chanReset();
      state_nxt.live = chanReset();
      state_nxt.pending = 1'b0;
    end
  end
  // ==========================================================================
  // State register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= '0;
      state_r.primary <= `SPWM_PRIMARY_RST;
      state_r.secondary <= `SPWM_SECONDARY_RST;
      state_r.prescale <= `SPWM_PRESCALE_RST;
      state_r.shadow <= CHAN_RST;
      state_r.live <= CHAN_RST;
      state_r.pinEnN <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end
  assign byteOut = state_r.rdata;
  assign addrAck = state_r.ack;
  assign ledOut = state_r.pinOut;
  assign ledOutEnN = state_r.pinEnN;
  assign prescaleOut = state_r.prescale;
  // ==========================================================================
  // Checks
  prescaleLock_a: assert property (@(posedge mclk) disable iff (rst)
    !state_r.primary[`SPWM_P_SLEEP] && !softReset |=> $stable(prescaleOut))
    else $error("prescale changed awake");
  extSticky_a: assert property (@(posedge mclk) disable iff (rst)
    state_r.primary[`SPWM_P_EXTERNAL_CLOCK_SELECT] && !softReset |=> state_r.primary[`SPWM_P_EXTERNAL_CLOCK_SELECT])
    else $error("external select cleared");
  sleepFreeze_a: assert property (@(posedge mclk) disable iff (rst)
    state_r.primary[`SPWM_P_SLEEP] |=> $stable(state_r.count) || state_r.count == 12'h000)
    else $error("counter ran in sleep");
  ptrWrap_a: assert property (@(posedge mclk) disable iff (rst)
    byteRead && state_r.primary[`SPWM_P_AUTOINC] && state_r.ptr == `SPWM_REG_CHAN_LAST
    |=> state_r.ptr == `SPWM_REG_PRIMARY) else $error("pointer did not wrap");
  bcastRead_a: assert property (@(posedge mclk) disable iff (rst)
    byteRead && state_r.ptr >= `SPWM_REG_BCAST_FIRST && state_r.ptr <= `SPWM_REG_BCAST_OFFH
    |=> byteOut == 8'h00) else $error("broadcast read nonzero");
  subAck_a: assert property (@(posedge mclk) disable iff (rst)
    addrMatch && addrKind == 2'd2 && !state_r.primary[`SPWM_P_SECONDARY_ADDR1_ENABLE] |=> !addrAck)
    else $error("sub address acked while off");
  disabledLow_a: assert property (@(posedge mclk) disable iff (rst)
    oeNSync && state_r.secondary[1:0] == 2'b00 |=> ledOut == '0 && ledOutEnN == '0)
    else $error("disabled outputs not low");
  resumeRead_a: assert property (@(posedge mclk) disable iff (rst)
    byteRead && state_r.ptr == `SPWM_REG_PRIMARY |=> byteOut[7] == $past(state_r.pending))
    else $error("resume bit misread");
  cStop_c: cover property (@(posedge mclk) disable iff (rst) busStop && state_r.live != state_r.shadow);
  cResume_c: cover property (@(posedge mclk) disable iff (rst) state_r.pending);
  cWrap_c: cover property (@(posedge mclk) disable iff (rst) tick && state_r.count == 12'hFFF);
endmodule

// ==== spwm_ctrl_model.sv ====
// Serial bus controller model issuing byte-port transfers to the PWM controller
`include "spwm_defines.svh"
module spwm_ctrl_model (
  // Clock
  input  wire logic       mclk,
  // Requests toward the device
  output logic            addrMatch,
  output logic [1:0]      addrKind,
  output logic            byteWrite,
  output logic            byteRead,
  output logic [7:0]      byteIn,
  output logic            busStop,
  // Answers from the device
  input  wire logic [7:0] byteOut,
  input  wire logic       addrAck
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Idle levels
  initial begin
    addrMatch = 1'b0;
    addrKind  = 2'h0;
    byteWrite = 1'b0;
    byteRead  = 1'b0;
    byteIn    = 8'h00;
    busStop   = 1'b0;
  end
  // Address phase; ack is sampled in the cycle after the request is taken
  task automatic pulseAddr(input logic [1:0] kind, output logic ack);
    @(negedge mclk);
    addrMatch = 1'b1;
    addrKind  = kind;
    @(negedge mclk);
    addrMatch = 1'b0;
    addrKind  = ~kind;
    ack       = addrAck;
  endtask
  // One written byte; released data line shows the inverse value
  task automatic sendByte(input logic [7:0] b);
    @(negedge mclk);
    byteWrite = 1'b1;
    byteIn    = b;
    @(negedge mclk);
    byteWrite = 1'b0;
    byteIn    = ~b;
  endtask
  // One read byte; read data holds until the next read
  task automatic getByte(output logic [7:0] b);
    @(negedge mclk);
    byteRead = 1'b1;
    @(negedge mclk);
    byteRead = 1'b0;
    @(negedge mclk);
    b = byteOut;
  endtask
  // Stop condition
  task automatic stopBus();
    @(negedge mclk);
    busStop = 1'b1;
    @(negedge mclk);
    busStop = 1'b0;
  endtask
  // Pointer byte first, then one data byte
  task automatic writeReg(input logic [7:0] ptr, input logic [7:0] data);
    logic ack;
    pulseAddr(2'h0, ack);
    sendByte(ptr);
    sendByte(data);
    stopBus();
  endtask
  // Pointer write, repeated address, one read
  task automatic readReg(input logic [7:0] ptr, output logic [7:0] data);
    logic ack;
    pulseAddr(2'h0, ack);
    sendByte(ptr);
    pulseAddr(2'h0, ack);
    getByte(data);
    stopBus();
  endtask
  // Oscillator settling time after clearing sleep
  task automatic wakeWait();
    repeat (`SPWM_OSC_WAKE_CYC) @(negedge mclk);
  endtask
  // Sleep first, then sleep together with external clock select
  task automatic selectExtClock();
    writeReg(8'h00, 8'h31);
    writeReg(8'h00, 8'h71);
  endtask
endmodule

// ==== tb_top.sv ====
// Self-checking testbench of the PWM controller mode and timing logic
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0] ptr;
    logic       wr;
    logic [7:0] data;
    logic [7:0] exp;
  } spwm_row_t;
  // ==========================================================================
  // Signals
  logic        mclk, rst, addrMatch, byteWrite, byteRead, busStop, softReset;
  logic        extClockPin, outEnableN, addrAck;
  logic [1:0]  addrKind;
  logic [7:0]  byteIn, byteOut, prescaleOut, rd;
  logic [15:0] ledOut, ledOutEnN;
  int          badCount, numChecks, cycles, width;
  logic        ack;
  spwm_row_t   rows [10] = '{
    '{8'h00, 1'b0, 8'h00, 8'h11}, '{8'h01, 1'b0, 8'h00, 8'h04},
    '{8'h07, 1'b0, 8'h00, 8'h00}, '{8'h09, 1'b0, 8'h00, 8'h10},
    '{8'hFE, 1'b0, 8'h00, 8'h1E}, '{8'hFE, 1'b1, 8'h00, 8'h00},
    '{8'h06, 1'b1, 8'hAB, 8'hAB}, '{8'h07, 1'b1, 8'hFF, 8'h1F},
    '{8'hFA, 1'b0, 8'h00, 8'h00}, '{8'h50, 1'b0, 8'h00, 8'h00}};
  logic [7:0]  burst [8] = '{8'h10, 8'h00, 8'h20, 8'h00, 8'hF0, 8'h0F, 8'h10, 8'h00};
  logic [7:0]  aiExp [7] = '{8'h00, 8'h10, 8'h31, 8'h00, 8'h00, 8'h00, 8'h31};
  logic [7:0]  disSec [4] = '{8'h04, 8'h05, 8'h01, 8'h06};
  logic [15:0] disLed [4] = '{16'h0000, 16'hFFFF, 16'h0000, 16'h0000};
  logic [15:0] disEn [4] = '{16'h0000, 16'h0000, 16'hFFFF, 16'hFFFF};
  // ==========================================================================
  // Controller model and device
  spwm_ctrl_model model (.mclk(mclk), .addrMatch(addrMatch), .addrKind(addrKind),
    .byteWrite(byteWrite), .byteRead(byteRead), .byteIn(byteIn), .busStop(busStop),
    .byteOut(byteOut), .addrAck(addrAck));
  spwm_top #(.CHANNELS(16)) dut (.mclk(mclk), .rst(rst), .addrMatch(addrMatch),
    .addrKind(addrKind), .byteWrite(byteWrite), .byteRead(byteRead), .byteIn(byteIn),
    .busStop(busStop), .softReset(softReset), .extClockPin(extClockPin),
    .outEnableN(outEnableN), .byteOut(byteOut), .addrAck(addrAck), .ledOut(ledOut),
    .ledOutEnN(ledOutEnN), .prescaleOut(prescaleOut));
  // Clocks: system clock and an unrelated external clock pin
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    extClockPin = 1'b0;
    #130;
    forever #400 extClockPin = ~extClockPin;
  end
  // Watchdog against hangs
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      badCount++;
      finishTest();
    end
  end
  // ==========================================================================
  // Comparison, verdict and pulse measurement
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    numChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("Error at %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic finishTest();
    if (badCount == 0 && numChecks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Cycles a channel stays at lvl, measured from its next entry into lvl
  task automatic measure(input int ch, input logic lvl, output int n);
    int k;
    k = 0;
    n = 0;
    while (ledOut[ch] !== ~lvl && k < 9000) begin
      @(negedge mclk);
      k++;
    end
    while (ledOut[ch] !== lvl && k < 9000) begin
      @(negedge mclk);
      k++;
    end
    while (ledOut[ch] === lvl && n < 9000) begin
      @(negedge mclk);
      n++;
    end
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    badCount = 0;
    numChecks = 0;
    rst = 1'b1;
    softReset = 1'b0;
    outEnableN = 1'b0;
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    // Register table rows: optional write, then read back
    foreach (rows[i]) begin
      if (rows[i].wr) model.writeReg(rows[i].ptr, rows[i].data);
      model.readReg(rows[i].ptr, rd);
      check(rd, rows[i].exp);
    end
    // Address answers: own and broadcast only, then all enables on
    for (int k = 0; k < 4; k++) begin
      model.pulseAddr(k[1:0], ack);
      model.stopBus();
      check(ack, (k < 2) ? 16'h0001 : 16'h0000);
    end
    model.writeReg(8'h00, 8'h1F);
    for (int k = 0; k < 4; k++) begin
      model.pulseAddr(k[1:0], ack);
      model.stopBus();
      check(ack, 16'h0001);
    end
    // Auto-increment reads wrap at 69 and after 254
    model.writeReg(8'h00, 8'h31);
    for (int j = 0; j < 2; j++) begin
      model.pulseAddr(2'h0, ack);
      model.sendByte(j == 0 ? 8'h44 : 8'hFC);
      model.pulseAddr(2'h0, ack);
      for (int k = 0; k < 3 + j; k++) begin
        model.getByte(rd);
        check(rd, aiExp[j * 3 + k]);
      end
      model.stopBus();
    end
    // Two channels by one burst, updated at stop; wake and measure
    model.pulseAddr(2'h0, ack);
    model.sendByte(8'h06);
    foreach (burst[i]) model.sendByte(burst[i]);
    model.stopBus();
    model.writeReg(8'h00, 8'h21);
    model.wakeWait();
    measure(0, 1'b1, width);
    check(width, 16'h0010);
    measure(1, 1'b1, width);
    check(width, 16'h0020);
    check(ledOutEnN, 16'h0000);
    model.writeReg(8'h01, 8'h14);
    measure(0, 1'b0, width);
    check(width, 16'h0010);
    // Disabled output states while enable is high
    outEnableN = 1'b1;
    foreach (disSec[i]) begin
      model.writeReg(8'h01, disSec[i]);
      repeat (6) @(negedge mclk);
      check(ledOutEnN, disEn[i]);
      if (disEn[i] == 16'h0000) check(ledOut, disLed[i]);
    end
    outEnableN = 1'b0;
    model.writeReg(8'h01, 8'h04);
    // Sleep while running sets resume; writing 0 keeps it, writing 1 restarts
    model.writeReg(8'h00, 8'h31);
    repeat (4200) @(negedge mclk);
    model.readReg(8'h00, rd);
    check(rd, 8'hB1);
    model.writeReg(8'h00, 8'h21);
    model.readReg(8'h00, rd);
    check(rd, 8'hA1);
    model.wakeWait();
    model.writeReg(8'h00, 8'hA1);
    model.readReg(8'h00, rd);
    check(rd, 8'h21);
    measure(0, 1'b1, width);
    check(width, 16'h0010);
    // Update on acknowledge: channel 2 turns fully on before the stop
    model.writeReg(8'h01, 8'h0C);
    model.pulseAddr(2'h0, ack);
    model.sendByte(8'h0E);
    for (int k = 0; k < 4; k++) model.sendByte((k == 1) ? 8'h10 : 8'h00);
    repeat (4) @(negedge mclk);
    check(ledOut[2], 16'h0001);
    model.stopBus();
    model.writeReg(8'h01, 8'h04);
    // Broadcast full on, then full off wins
    model.writeReg(8'hFD, 8'h00);
    model.writeReg(8'hFB, 8'h10);
    repeat (6) @(negedge mclk);
    check(ledOut, 16'hFFFF);
    model.writeReg(8'hFD, 8'h10);
    repeat (6) @(negedge mclk);
    check(ledOut, 16'h0000);
    // Sleep after orderly shutdown leaves resume clear
    model.writeReg(8'h00, 8'h31);
    repeat (4200) @(negedge mclk);
    model.readReg(8'h00, rd);
    check(rd, 8'h31);
    // Prescaler write refused while awake
    model.writeReg(8'h00, 8'h21);
    model.writeReg(8'hFE, 8'h77);
    check(prescaleOut, 8'h00);
    // Sticky external clock select, kept through a write of 0, cleared by soft reset
    model.selectExtClock();
    model.writeReg(8'h00, 8'h21);
    model.readReg(8'h00, rd);
    check(rd, 8'h61);
    @(negedge mclk);
    softReset = 1'b1;
    @(negedge mclk);
    softReset = 1'b0;
    model.readReg(8'h00, rd);
    check(rd, 8'h11);
    check(prescaleOut, 8'h1E);
    // Mid-run hardware reset restores the defaults
    model.writeReg(8'hFE, 8'h55);
    rst = 1'b1;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    check(prescaleOut, 8'h1E);
    model.readReg(8'h00, rd);
    check(rd, 8'h11);
    finishTest();
  end
endmodule
